// file: fbadd_pkg.sv
// constants and types shared by the 4-bit addition block
`default_nettype none
package fbadd_pkg;
  localparam int unsigned NIB_W     = 4;
  localparam int unsigned SUM_W     = NIB_W + 1;
  localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
  localparam logic             CARRY_RST = 1'b0;
  localparam logic             SKIP_RST  = 1'b0;

  // operation select presented by the instruction decoder
  typedef enum logic [1:0]
  {
    FBADD_OP_NONE,
    FBADD_OP_IMM,
    FBADD_OP_MEM,
    FBADD_OP_MEMC
  } fbadd_op_type;
endpackage
`default_nettype wire

// file: fbadd_if.sv
// interface between the control top and the adder core
`timescale 1ns/1ns
`default_nettype none
interface fbadd_if;
  import fbadd_pkg::*;
  logic [NIB_W-1:0] opA;
  logic [NIB_W-1:0] opB;
  logic             carryIn;
  logic [NIB_W-1:0] sum;
  logic             carryOut;
  modport ctrl (output opA, output opB, output carryIn,
                input sum, input carryOut);
  modport core (input opA, input opB, input carryIn,
                output sum, output carryOut);
endinterface
`default_nettype wire

// file: fbadd_core.sv
// 4-bit adder with carry in and carry out
`timescale 1ns/1ns
`default_nettype none
module fbadd_core
  import fbadd_pkg::*;
(
  fbadd_if.core bus
);
  logic [SUM_W-1:0] wide;

  // carry out is the bit above the top accumulator bit
  always_comb
  begin
    wide = {1'b0, bus.opA} + {1'b0, bus.opB} + {{NIB_W{1'b0}}, bus.carryIn};
    bus.sum      = wide[NIB_W-1:0];
    bus.carryOut = wide[NIB_W];
  end
endmodule
`default_nettype wire

// file: fbadd_top.sv
// accumulator, carry flag and skip logic for the addition instructions
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Function
// - immediate 0..15 added to accumulator, one cycle
// - immediate add keeps carry flag unchanged
// - immediate add without overflow skips next
// - immediate add with overflow executes next
// - memory add into accumulator, carry unchanged
// - memory plus carry add updates carry flag
module fbadd_top
  import fbadd_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire fbadd_op_type     opSel,
  input  wire logic [NIB_W-1:0] immValue,
  input  wire logic [NIB_W-1:0] memNibble,
  output var  logic [NIB_W-1:0] accOut,
  output var  logic             carry_flag,
  output var  logic             skipNext
);
  //////////////////////////////////////////////////////////////////////
  // behaviour in brief:
  //   one add is taken at each rising edge where opSel is not NONE
  //   the accumulator keeps the low nibble of the sum
  //   only the add with carry reads or writes the carry flag
  //   only the immediate add may ask the sequencer to skip
  //   results show right after the edge that takes the add
  //   back to back adds are allowed; NONE holds the accumulator and carry flag and clears the skip register

  // shared adder: operand steering here, arithmetic in uCore
  fbadd_if addBus ();

  // decoded operation strobes, at most one of opIsImm, opIsMem, opIsMemc high; opIsAdd is their OR
  logic             opIsImm;
  logic             opIsMem;
  logic             opIsMemc;
  logic             opIsAdd;

  // accumulator state
  logic [NIB_W-1:0] acc_q;
  logic [NIB_W-1:0] acc_d;

  // carry flag state
  logic             carry_q;
  logic             carry_d;

  // skip request state
  logic             skip_q;
  logic             skip_d;

  // adder results as used by the state logic
  logic [NIB_W-1:0] addResult;
  logic             addOverflow;

  //////////////////////////////////////////////////////////////////////
  // the adder is kept apart so the carry chain can be swapped alone
  fbadd_core uCore
  (
    .bus (addBus.core)
  );

  //////////////////////////////////////////////////////////////////////
  // operation decode; NONE leaves the accumulator and carry flag as they are and clears the skip register
  always_comb
  begin
    opIsImm  = 1'b0;
    opIsMem  = 1'b0;
    opIsMemc = 1'b0;
    case (opSel)
      FBADD_OP_IMM:
      begin
        opIsImm = 1'b1;
      end
      FBADD_OP_MEM:
      begin
        opIsMem = 1'b1;
      end
      FBADD_OP_MEMC:
      begin
        opIsMemc = 1'b1;
      end
      default:
      begin
        opIsImm  = 1'b0;
        opIsMem  = 1'b0;
        opIsMemc = 1'b0;
      end
    endcase
  end

  // every one of the three adds writes the accumulator
  assign opIsAdd = opIsImm | opIsMem | opIsMemc;

  //////////////////////////////////////////////////////////////////////
  // operand steering; memNibble is the nibble the data_pointer selects
  // the carry input stays low unless the add with carry is chosen
  always_comb
  begin
    addBus.opA     = acc_q;
    addBus.opB     = memNibble;
    addBus.carryIn = 1'b0;
    case (opSel)
      FBADD_OP_IMM:
      begin
        addBus.opB = immValue;
      end
      FBADD_OP_MEM:
      begin
        addBus.opB = memNibble;
      end
      FBADD_OP_MEMC:
      begin
        addBus.opB     = memNibble;
        addBus.carryIn = carry_q;
      end
      default:
      begin
        addBus.opB     = memNibble;
        addBus.carryIn = 1'b0;
      end
    endcase
  end

  // low nibble of the sum and the carry out of the top bit
  assign addResult   = addBus.sum;
  assign addOverflow = addBus.carryOut;

  //////////////////////////////////////////////////////////////////////
  // accumulator next value; any add writes it, NONE holds it
  always_comb
  begin
    acc_d = acc_q;
    if (opIsAdd)
    begin
      acc_d = addResult;
    end
  end

  // accumulator register; cleared at once so the core starts at zero
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_q <= ACC_RST;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // carry flag next value; only the add with carry may move it, so a
  // plain add never disturbs a carry chain the program is building
  always_comb
  begin
    carry_d = carry_q;
    case (opSel)
      FBADD_OP_IMM:
      begin
        carry_d = carry_q;
      end
      FBADD_OP_MEM:
      begin
        carry_d = carry_q;
      end
      FBADD_OP_MEMC:
      begin
        carry_d = addOverflow;
      end
      default:
      begin
        carry_d = carry_q;
      end
    endcase
  end

  // carry flag register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      carry_q <= CARRY_RST;
    end
    else
    begin
      carry_q <= carry_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // skip request; registered, so the sequencer sees it one cycle after
  // the add; the price is that it cannot act in the add's own cycle
  always_comb
  begin
    skip_d = 1'b0;
    if (opIsImm)
    begin
      skip_d = ~addOverflow;
    end
  end

  // skip register; a pulse of one cycle, dropped on the next edge unless another immediate add without overflow sets it again
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      skip_q <= SKIP_RST;
    end
    else
    begin
      skip_q <= skip_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs come straight from the registers
  assign accOut     = acc_q;
  assign carry_flag = carry_q;
  assign skipNext   = skip_q;
endmodule
`default_nettype wire

// file: fbadd_props.sv
// port checks for the add block
`timescale 1ns/1ns
`default_nettype none
module fbadd_props
  import fbadd_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             nrst,
  input wire fbadd_op_type     opSel,
  input wire logic [NIB_W-1:0] immValue,
  input wire logic [NIB_W-1:0] memNibble,
  input wire logic [NIB_W-1:0] accOut,
  input wire logic             carry_flag,
  input wire logic             skipNext
);
  // every check runs on the one clock and sleeps during reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////
  // sums worked out from the rules, one bit wider for the carry out
  logic [SUM_W-1:0] immSum;
  logic [SUM_W-1:0] memSum;
  logic [SUM_W-1:0] memcSum;

  assign immSum  = {1'b0, accOut} + {1'b0, immValue};
  assign memSum  = {1'b0, accOut} + {1'b0, memNibble};
  assign memcSum = memSum + {{NIB_W{1'b0}}, carry_flag};

  ////////////////////////////////////////////////////////////////////
  // immediate add: result, carry kept, skip on no overflow
  chk_imm_acc: assert property (
    opSel == FBADD_OP_IMM |=> accOut == $past(immSum[NIB_W-1:0]))
    else $error("immediate add result wrong");
  chk_imm_carry: assert property (
    opSel == FBADD_OP_IMM |=> $stable(carry_flag))
    else $error("immediate add moved the carry flag");
  chk_skip_set: assert property (
    opSel == FBADD_OP_IMM && !immSum[NIB_W] |=> skipNext)
    else $error("no skip after immediate add without overflow");
  chk_skip_clear: assert property (
    opSel == FBADD_OP_IMM && immSum[NIB_W] |=> !skipNext)
    else $error("skip after immediate add with overflow");

  ////////////////////////////////////////////////////////////////////
  // memory adds: result, and carry kept or taken from the sum
  chk_mem_acc: assert property (
    opSel == FBADD_OP_MEM |=> accOut == $past(memSum[NIB_W-1:0]))
    else $error("memory add result wrong");
  chk_mem_carry: assert property (
    opSel == FBADD_OP_MEM |=> $stable(carry_flag))
    else $error("memory add moved the carry flag");
  chk_memc_acc: assert property (
    opSel == FBADD_OP_MEMC |=> accOut == $past(memcSum[NIB_W-1:0]))
    else $error("memory add with carry result wrong");
  chk_memc_carry: assert property (
    opSel == FBADD_OP_MEMC |=> carry_flag == $past(memcSum[NIB_W]))
    else $error("memory add with carry left a wrong carry flag");
endmodule

bind fbadd_top fbadd_props chk
(
  .ref_clk    (ref_clk),
  .nrst       (nrst),
  .opSel      (opSel),
  .immValue   (immValue),
  .memNibble  (memNibble),
  .accOut     (accOut),
  .carry_flag (carry_flag),
  .skipNext   (skipNext)
);
`default_nettype wire

// file: fbadd_top_tb.sv
// add block bench
`timescale 1ns/1ns
`default_nettype none
module fbadd_top_tb;
  import fbadd_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, cy = 1'b0, carry_flag, skipNext;
  fbadd_op_type opSel = FBADD_OP_NONE;
  logic [3:0] immValue = 4'h0, memNibble = 4'h0, accOut;
  logic [4:0] sum = 5'h00;
  logic skipExp = 1'b0;
  int num_errors = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  fbadd_top dut
  (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .opSel      (opSel),
    .immValue   (immValue),
    .memNibble  (memNibble),
    .accOut     (accOut),
    .carry_flag (carry_flag),
    .skipNext   (skipNext)
  );
  task automatic check(string s, logic [4:0] seen, exp);
    checks_done++;
    num_errors += seen !== exp;
    if (seen !== exp)
      $display("BAD %s exp %h saw %h", s, exp, seen);
  endtask
  // NONE after each op shows a stuck op or a long skip
  task automatic doOp(fbadd_op_type op, logic [3:0] i, m);
    @(posedge ref_clk);
    opSel <= op;
    {immValue, memNibble} <= {i, m};
    sum = sum[3:0] + (op == FBADD_OP_IMM ? i : m)
        + (op == FBADD_OP_MEMC && cy);
    cy = op == FBADD_OP_MEMC ? sum[4] : cy;
    skipExp = op == FBADD_OP_IMM && !sum[4];
    @(posedge ref_clk);
    opSel <= FBADD_OP_NONE;
    @(negedge ref_clk);
    check("acc", accOut, sum[3:0]);
    check("cy", carry_flag, cy);
    check("skip", skipNext, skipExp);
  endtask
  task automatic scAll();
    for (int n = 0; n < 48; n++)
      doOp(fbadd_op_type'(n % 3 + 1), 4'(n), 4'(n * 5));
  endtask
  // two adds on adjacent edges: the skip pulse must not stretch
  task automatic scBurst();
    @(posedge ref_clk);
    opSel <= FBADD_OP_IMM;
    immValue <= 4'h0;                  // adding zero never overflows
    @(posedge ref_clk);
    opSel <= FBADD_OP_MEMC;
    memNibble <= 4'h1;
    @(negedge ref_clk);
    check("acc", accOut, sum[3:0]);
    check("skip", skipNext, 1'b1);
    @(posedge ref_clk);
    opSel <= FBADD_OP_NONE;
    sum = sum[3:0] + 4'h1 + cy;
    cy = sum[4];
    @(negedge ref_clk);
    check("acc", accOut, sum[3:0]);
    check("cy", carry_flag, cy);
    check("skip", skipNext, 1'b0);
  endtask
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    scAll();
    scBurst();
    summarize();
  end
endmodule
`default_nettype wire
